/* logic/drive_start_stop_sequencer.sv */
// What this block does
// - macro 0..3 keeps overwriting terminal routes and latch enable
// - macro 4 leaves routes and latch enable to software
// - new macro routing applies only after a drive reset
// - macros 0,1: b fwd, c rev; 1 adds a permit, latched
// - macros 2,3: b run, c direction; 3 adds a permit, latched
// - latched: no run without active run permit
// - latched: permit loss clears the latched run and stops
// - catch off: start output at zero and ramp
// - catch on, open loop: run speed test, then start at measured speed, or at zero if the measured direction is not selected
// - skip test from stop state, each-run voltage mode, or first enable in each-enable voltage mode
// - test lasts about 250ms, longer for long rotor time constant
// - test drives rated magnetising current
// - catch select: 0 off, 1 all, 2 positive, 3 negative
// - closed loop, catch clear: reference starts at zero
// - closed loop, catch set: reference preloaded with speed
// - scaling drives detection in open loop or feedback 1 or 3
`timescale 1ns/1ps
`default_nettype none
`include "drive_seq_defines.svh"
module drive_start_stop_sequencer
   import drive_seq_pkg::*;
#(
   parameter int unsigned TEST_CYC   = `CATCH_TEST_CYC,
   parameter int unsigned SPEED_W    = 16
) (
   // clock and reset
   input  wire logic               CLK,
   input  wire logic               RST,
   // register port
   input  wire logic [3:0]         ADDR,
   input  wire logic [31:0]        WDATA,
   input  wire logic               WR,
   input  wire logic               RD,
   output logic      [31:0]        RDATA,
   // command terminals (pins)
   input  wire logic               COMMAND_TERMINAL_A,
   input  wire logic               COMMAND_TERMINAL_B,
   input  wire logic               COMMAND_TERMINAL_C,
   // drive status from the motor side
   input  wire logic               CLOSED_LOOP,
   input  wire logic [1:0]         FEEDBACK_MODE_SELECT,
   input  wire logic [2:0]         VOLTAGE_MODE_SELECT,
   input  wire logic               LONG_ROTOR_TC,
   input  wire logic               STOP_STATE,
   input  wire logic [SPEED_W-1:0] MEASURED_SPEED,
   input  wire logic               MEASURED_NEG,
   // drive outputs
   output logic                    RUN_ENABLE,
   output logic                    RUN_REVERSE,
   output logic                    CATCH_TEST_ACTIVE,
   output logic                    MAGNETISE_RATED,
   output logic                    PRELOAD_VALID,
   output logic      [SPEED_W-1:0] POST_RAMP_REFERENCE,
   output logic      [6:0]         DETECT_SCALING
);
   logic [2:0] macro_q, macro_live_q;
   logic       latch_q;
   logic [1:0] catch_q;
   logic [6:0] scale_q;
   logic [2:0] route_a_q, route_b_q, route_c_q;
   logic       first_en_q, latch_run_q;
   logic [31:0] tcnt_q;
   sst_t       st_q, st_d;
   logic       ta, tb, tc;

   drive_seq_sync u_sa (.CLK(CLK), .RST(RST), .pin(COMMAND_TERMINAL_A), .level(ta));
   drive_seq_sync u_sb (.CLK(CLK), .RST(RST), .pin(COMMAND_TERMINAL_B), .level(tb));
   drive_seq_sync u_sc (.CLK(CLK), .RST(RST), .pin(COMMAND_TERMINAL_C), .level(tc));

   // register decode
   wire wr_macro = WR && ADDR == `OFS_MACRO;
   wire wr_latch = WR && ADDR == `OFS_LATCH;
   wire wr_catch = WR && ADDR == `OFS_CATCH;
   wire wr_scale = WR && ADDR == `OFS_SCALE;
   wire wr_route = WR && ADDR == `OFS_ROUTE;
   wire wr_ctrl  = WR && ADDR == `OFS_CONTROL;
   wire macro_fixed = macro_live_q <= 3'h3;
   wire soft_reset  = wr_ctrl && WDATA[0];

   // macro tables
   wire [2:0] m_a = macro_live_q[0] ? DEST_PERMIT : DEST_NONE;
   wire [2:0] m_b = macro_live_q[1] ? DEST_RUN : DEST_FWD;
   wire [2:0] m_c = macro_live_q[1] ? DEST_DIR : DEST_REV;
   wire       m_l = macro_live_q[0];

   // terminal routing to commands
   function automatic logic hit(input logic [2:0] r, input logic [2:0] d, input logic v);
      hit = (r == d) && v;
   endfunction
   wire c_fwd = hit(route_a_q, DEST_FWD, ta) | hit(route_b_q, DEST_FWD, tb) | hit(route_c_q, DEST_FWD, tc);
   wire c_rev = hit(route_a_q, DEST_REV, ta) | hit(route_b_q, DEST_REV, tb) | hit(route_c_q, DEST_REV, tc);
   wire c_run = hit(route_a_q, DEST_RUN, ta) | hit(route_b_q, DEST_RUN, tb) | hit(route_c_q, DEST_RUN, tc);
   wire c_dir = hit(route_a_q, DEST_DIR, ta) | hit(route_b_q, DEST_DIR, tb) | hit(route_c_q, DEST_DIR, tc);
   wire c_prm = hit(route_a_q, DEST_PERMIT, ta) | hit(route_b_q, DEST_PERMIT, tb)
              | hit(route_c_q, DEST_PERMIT, tc);
   wire run_req  = c_fwd | c_rev | c_run;
   wire rev_req  = c_rev | (c_run & c_dir);
   // latched: a run press with permit present sets the latch, permit loss clears it
   wire run_cmd  = latch_q ? (latch_run_q | run_req) & c_prm : run_req;
   wire start    = run_cmd && !RUN_ENABLE;
   wire open_loop = !CLOSED_LOOP;
   wire skip_test = STOP_STATE
                  | (VOLTAGE_MODE_SELECT == VM_EACH_RUN)
                  | (VOLTAGE_MODE_SELECT == VM_EACH_EN && first_en_q);
   wire dir_ok = catch_q == 2'h1 || (catch_q == 2'h2 && !MEASURED_NEG)
               || (catch_q == 2'h3 && MEASURED_NEG);
   wire [31:0] test_len = LONG_ROTOR_TC ? TEST_CYC * 2 : TEST_CYC;

   always_ff @(posedge CLK) begin
      if (RST) begin
         macro_q <= `RST_MACRO;
         macro_live_q <= `RST_MACRO;
      end else begin
         // whole word compared so that high garbage bits cannot alias a legal macro
         if (wr_macro && WDATA <= 32'h0000_0004)
            macro_q <= WDATA[2:0];
         if (soft_reset)
            macro_live_q <= macro_q;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         latch_q   <= `RST_LATCH;
         route_a_q <= `RST_ROUTE_A;
         route_b_q <= `RST_ROUTE_B;
         route_c_q <= `RST_ROUTE_C;
      end else if (macro_fixed) begin
         latch_q   <= m_l;
         route_a_q <= m_a;
         route_b_q <= m_b;
         route_c_q <= m_c;
      end else begin
         if (wr_latch)
            latch_q <= WDATA[0];
         if (wr_route) begin
            route_a_q <= WDATA[`ROUTE_A_LSB +: 3];
            route_b_q <= WDATA[`ROUTE_B_LSB +: 3];
            route_c_q <= WDATA[`ROUTE_C_LSB +: 3];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         catch_q <= `RST_CATCH;
         scale_q <= `RST_SCALE;
      end else begin
         if (wr_catch)
            catch_q <= WDATA[1:0];
         if (wr_scale && WDATA <= 32'h0000_0064)
            scale_q <= WDATA[6:0];
      end
   end

   always_ff @(posedge CLK) begin
      if (RST)
         latch_run_q <= 1'b0;
      else if (!c_prm || !latch_q)
         latch_run_q <= 1'b0;
      else if (run_req)
         latch_run_q <= 1'b1;
   end

   // start sequence
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_STOP: begin
            if (start) begin
               if (catch_q == 2'h0 || (skip_test && open_loop))
                  st_d = ST_ZERO;
               else if (open_loop)
                  st_d = ST_TEST;
               else
                  st_d = ST_LOAD;
            end
         end
         ST_TEST: begin
            if (!run_cmd)
               st_d = ST_STOP;
            else if (tcnt_q + 32'h0000_0001 >= test_len)
               st_d = dir_ok ? ST_LOAD : ST_ZERO;
         end
         ST_LOAD, ST_ZERO: st_d = run_cmd ? ST_RUN : ST_STOP;
         ST_RUN: begin
            if (!run_cmd)
               st_d = ST_STOP;
         end
         default: st_d = ST_STOP;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         st_q       <= ST_STOP;
         tcnt_q     <= 32'h0000_0000;
         first_en_q <= 1'b1;
      end else begin
         st_q   <= st_d;
         tcnt_q <= (st_q == ST_TEST) ? tcnt_q + 32'h0000_0001 : 32'h0000_0000;
         if (start)
            first_en_q <= 1'b0;
      end
   end

   // outputs
   always_ff @(posedge CLK) begin
      if (RST) begin
         RUN_ENABLE          <= 1'b0;
         RUN_REVERSE         <= 1'b0;
         CATCH_TEST_ACTIVE   <= 1'b0;
         MAGNETISE_RATED     <= 1'b0;
         PRELOAD_VALID       <= 1'b0;
         POST_RAMP_REFERENCE <= '0;
         DETECT_SCALING      <= `RST_SCALE;
      end else begin
         RUN_ENABLE        <= (st_d != ST_STOP);
         RUN_REVERSE       <= rev_req;
         CATCH_TEST_ACTIVE <= (st_d == ST_TEST);
         MAGNETISE_RATED   <= (st_d == ST_TEST);
         PRELOAD_VALID     <= (st_d == ST_LOAD) || (st_d == ST_ZERO);
         if (st_d == ST_LOAD)
            POST_RAMP_REFERENCE <= MEASURED_SPEED;
         else if (st_d == ST_ZERO)
            POST_RAMP_REFERENCE <= '0;
         DETECT_SCALING <= (open_loop || FEEDBACK_MODE_SELECT == 2'h1
                           || FEEDBACK_MODE_SELECT == 2'h3) ? scale_q : 7'h00;
      end
   end

   // read port
   logic [31:0] rmux;
   always_comb begin
      case (ADDR)
         `OFS_MACRO:      rmux = {29'h0, macro_q};
         `OFS_LATCH:      rmux = {31'h0, latch_q};
         `OFS_CATCH:      rmux = {30'h0, catch_q};
         `OFS_SCALE:      rmux = {25'h0, scale_q};
         `OFS_ROUTE:      rmux = {21'h0, route_c_q, 1'b0, route_b_q, 1'b0, route_a_q};
         `OFS_STATUS:     rmux = {24'h0, macro_live_q, st_q};
         `OFS_MEAS_SPEED: rmux = 32'(POST_RAMP_REFERENCE);
         default:         rmux = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge CLK) begin
      if (RST)
         RDATA <= 32'h0000_0000;
      else
         RDATA <= RD ? rmux : 32'h0000_0000;
   end

   property p_macro_route;
      @(posedge CLK) disable iff (RST) macro_fixed |=> latch_q == $past(m_l);
   endproperty
   a_macro_route: assert property (p_macro_route) else $error("latch not forced");
   property p_user;
      @(posedge CLK) disable iff (RST) !macro_fixed && !wr_latch |=> latch_q == $past(latch_q);
   endproperty
   a_user: assert property (p_user) else $error("latch changed in user mode");
   property p_reset_apply;
      @(posedge CLK) disable iff (RST) !soft_reset |=> $stable(macro_live_q);
   endproperty
   a_reset_apply: assert property (p_reset_apply) else $error("macro applied early");
   property p_permit;
      @(posedge CLK) disable iff (RST) latch_q && !c_prm && st_q == ST_STOP |=> !RUN_ENABLE;
   endproperty
   a_permit: assert property (p_permit) else $error("ran without permit");
   property p_drop;
      @(posedge CLK) disable iff (RST) latch_q && !c_prm |=> !latch_run_q;
   endproperty
   a_drop: assert property (p_drop) else $error("latch kept");
   property p_zero;
      @(posedge CLK) disable iff (RST) st_q == ST_STOP && start && catch_q == 2'h0 |=> POST_RAMP_REFERENCE == '0;
   endproperty
   a_zero: assert property (p_zero) else $error("no zero start");
   property p_test;
      @(posedge CLK) disable iff (RST) st_q == ST_STOP && start && open_loop && catch_q != 2'h0 && !skip_test
         |=> CATCH_TEST_ACTIVE && MAGNETISE_RATED;
   endproperty
   a_test: assert property (p_test) else $error("test not started");
   property p_len;
      @(posedge CLK) disable iff (RST) st_q == ST_TEST |-> tcnt_q < test_len;
   endproperty
   a_len: assert property (p_len) else $error("test too long");
   c_test: cover property (@(posedge CLK) CATCH_TEST_ACTIVE ##1 PRELOAD_VALID);
   c_latch: cover property (@(posedge CLK) latch_run_q ##1 !latch_run_q);
   c_user: cover property (@(posedge CLK) macro_live_q == 3'h4 && wr_route);
endmodule : drive_start_stop_sequencer
`default_nettype wire

/* shared/drive_seq_defines.svh */
`ifndef DRIVE_SEQ_DEFINES_SVH
`define DRIVE_SEQ_DEFINES_SVH
// register offsets (word index on the plain port)
`define OFS_MACRO        4'h0
`define OFS_LATCH        4'h1
`define OFS_CATCH        4'h2
`define OFS_SCALE        4'h3
`define OFS_ROUTE        4'h4
`define OFS_CONTROL      4'h5
`define OFS_STATUS       4'h6
`define OFS_MEAS_SPEED   4'h7
// reset values
`define RST_MACRO        3'h0
`define RST_LATCH        1'h0
`define RST_CATCH        2'h0
`define RST_SCALE        7'h0a
`define RST_ROUTE_A      3'h0
`define RST_ROUTE_B      3'h1
`define RST_ROUTE_C      3'h2
// route field positions in the routing register
`define ROUTE_A_LSB      0
`define ROUTE_B_LSB      4
`define ROUTE_C_LSB      8
// timing
`define CLK_NS           8
`define CATCH_TEST_MS    250
`define CATCH_TEST_CYC   ((`CATCH_TEST_MS * 1000000) / `CLK_NS)
`endif

/* shared/drive_seq_pkg.sv */
`default_nettype none
package drive_seq_pkg;
   // destination codes for a command terminal
   typedef enum logic [2:0] {
      DEST_NONE   = 3'h0,
      DEST_FWD    = 3'h1,
      DEST_REV    = 3'h2,
      DEST_RUN    = 3'h3,
      DEST_DIR    = 3'h4,
      DEST_PERMIT = 3'h5
   } dest_t;
   typedef enum logic [2:0] {
      VM_OTHER   = 3'h0,
      VM_EACH_EN = 3'h1,
      VM_EACH_RUN= 3'h2
   } vmode_t;
   typedef enum logic [4:0] {
      ST_STOP  = 5'b00001,
      ST_TEST  = 5'b00010,
      ST_LOAD  = 5'b00100,
      ST_ZERO  = 5'b01000,
      ST_RUN   = 5'b10000
   } sst_t;
endpackage : drive_seq_pkg
`default_nettype wire

/* logic/drive_seq_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for one pin
module drive_seq_sync (
   input  wire logic CLK,
   input  wire logic RST,
   input  wire logic pin,
   output logic      level
);
   logic meta_q;
   always_ff @(posedge CLK) begin
      if (RST) begin
         meta_q <= 1'b0;
         level  <= 1'b0;
      end else begin
         meta_q <= pin;
         level  <= meta_q;
      end
   end
endmodule : drive_seq_sync
`default_nettype wire

/* tb/motor_model.sv */
`timescale 1ns/1ps
`default_nettype none
module motor_model #(
   parameter int unsigned SPEED_W = 16
) (
   // clock and reset
   input  wire logic               clk,
   input  wire logic               rst,
   // shaft state set by the bench
   input  wire logic [SPEED_W-1:0] spin_speed,
   input  wire logic               spin_neg,
   // speed sensing toward the drive
   output logic      [SPEED_W-1:0] measured_speed,
   output logic                    measured_neg
);
   // sensing lags the shaft by one cycle, as a sampled estimate would
   always_ff @(posedge clk) begin
      if (rst) begin
         measured_speed <= '0;
         measured_neg   <= 1'b0;
      end else begin
         measured_speed <= spin_speed;
         measured_neg   <= spin_neg;
      end
   end
endmodule : motor_model
`default_nettype wire

/* tb/test_drive_start_stop_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "drive_seq_defines.svh"
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
   $display("BAD t=%0t %s got %h exp %h", $time, m, g, e); end end
module test_drive_start_stop_sequencer;
   import drive_seq_pkg::*;
   localparam int TEST_CYC = 20;
   logic        clk, rst, wr_s, rd_s, pin_a, pin_b, pin_c, closed, ltc, stop_st, spin_neg, mneg;
   logic        run_en, run_rev, cat, mag, preload;
   logic [3:0]  addr;
   logic [31:0] wdata, rdata;
   logic [1:0]  fbk;
   logic [2:0]  vmode;
   logic [15:0] spin_speed, mspeed, ref_out;
   logic [6:0]  dscale;
   int          n_mismatch = 0;
   int          compares = 0;
   // set after a drive reset until the first run, mirrors the first-enable case
   bit          fresh = 1'b0;

   drive_start_stop_sequencer #(.TEST_CYC(TEST_CYC), .SPEED_W(16)) drive_start_stop_sequencer_i (
      .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
      .COMMAND_TERMINAL_A(pin_a), .COMMAND_TERMINAL_B(pin_b), .COMMAND_TERMINAL_C(pin_c),
      .CLOSED_LOOP(closed), .FEEDBACK_MODE_SELECT(fbk), .VOLTAGE_MODE_SELECT(vmode),
      .LONG_ROTOR_TC(ltc), .STOP_STATE(stop_st), .MEASURED_SPEED(mspeed), .MEASURED_NEG(mneg),
      .RUN_ENABLE(run_en), .RUN_REVERSE(run_rev), .CATCH_TEST_ACTIVE(cat), .MAGNETISE_RATED(mag),
      .PRELOAD_VALID(preload), .POST_RAMP_REFERENCE(ref_out), .DETECT_SCALING(dscale));
   motor_model #(.SPEED_W(16)) motor_model_i (
      .clk(clk), .rst(rst), .spin_speed(spin_speed), .spin_neg(spin_neg),
      .measured_speed(mspeed), .measured_neg(mneg));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge clk);
      wr_s  <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 d = rdata;
   endtask : reg_read

   task automatic chk_reg(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] d;
      reg_read(a, d);
      `CHK(d, e, "register")
   endtask : chk_reg

   // a new macro only lands through the drive reset bit
   task automatic apply_macro(input logic [2:0] m);
      reg_write(`OFS_MACRO, {29'h0, m});
      reg_write(`OFS_CONTROL, 32'h0000_0001);
      reg_write(`OFS_CONTROL, 32'h0000_0000);
      cyc(3);
   endtask : apply_macro

   // pins pass two sync flops and a register, so 6 cycles is ample
   task automatic set_pins(input logic a, input logic b, input logic c);
      @(posedge clk);
      pin_a <= a;
      pin_b <= b;
      pin_c <= c;
      cyc(6);
   endtask : set_pins

   function automatic logic [31:0] exp_route(input int m);
      dest_t a, b, c;
      a = (m == 1 || m == 3) ? DEST_PERMIT : DEST_NONE;
      b = (m < 2) ? DEST_FWD : DEST_RUN;
      c = (m < 2) ? DEST_REV : DEST_DIR;
      return {21'h0, c, 1'b0, b, 1'b0, a};
   endfunction : exp_route

   task automatic spin_run(input int sel, input logic stp, input logic [2:0] vm, input logic cl);
      logic [15:0] spd;
      logic        neg;
      logic        pre;
      int          n;
      int          en;
      int          n_pre;
      spd = 16'($urandom);
      neg = 1'($urandom);
      n = 0;
      n_pre = 0;
      reg_write(`OFS_CATCH, 32'(sel));
      @(posedge clk);
      spin_speed <= spd;
      spin_neg   <= neg;
      ltc        <= 1'($urandom);
      stop_st    <= stp;
      vmode      <= vm;
      closed     <= cl;
      fbk        <= 2'($urandom);
      @(posedge clk);
      pin_b <= 1'b1;
      repeat (3 * TEST_CYC + 20) begin
         @(posedge clk);
         #1 n += int'(cat);
         n_pre += int'(preload);
         `CHK(mag, cat, "magnetise")
      end
      en = (sel != 0 && !stp && vm != 3'h2 && !(vm == 3'h1 && fresh) && !cl) ? TEST_CYC * (ltc ? 2 : 1) : 0;
      pre = cl ? (sel != 0) : (en != 0 && (sel == 1 || (sel == 2 && !neg) || (sel == 3 && neg)));
      `CHK(n, en, "test length")
      // the load strobe stands one cycle, so count it over the whole window
      `CHK(n_pre, 1, "preload pulse")
      `CHK(ref_out, pre ? spd : 16'h0000, "reference")
      @(posedge clk);
      pin_b <= 1'b0;
      fresh = 1'b0;
      cyc(8);
   endtask : spin_run

   task automatic complete_run;
      $display("mismatches %0d of %0d compares", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run

   initial begin
      #200000;
      n_mismatch++;
      complete_run();
   end

   initial begin
      int          ml[4] = '{1, 2, 3, 0};
      int          prev;
      logic [31:0] d;
      logic [31:0] v;
      {wr_s, rd_s, pin_a, pin_b, pin_c, closed, ltc, stop_st, spin_neg} = '0;
      {addr, wdata, fbk, vmode, spin_speed} = '0;
      rst = 1'b1;
      void'($urandom(68));
      cyc(6);
      rst <= 1'b0;
      chk_reg(`OFS_MACRO, 32'h0000_0000);
      chk_reg(`OFS_LATCH, 32'h0000_0000);
      chk_reg(`OFS_CATCH, 32'h0000_0000);
      chk_reg(`OFS_SCALE, 32'h0000_000a);
      chk_reg(4'hf, 32'h0000_0000);
      chk_reg(`OFS_ROUTE, exp_route(0));
      `CHK(dscale, 7'h0a, "scale output")
      prev = 0;
      foreach (ml[i]) begin
         reg_write(`OFS_MACRO, 32'(ml[i]));
         reg_read(`OFS_STATUS, d);
         `CHK(d[7:5], 3'(prev), "live macro early")
         chk_reg(`OFS_ROUTE, exp_route(prev));
         apply_macro(3'(ml[i]));
         reg_write(`OFS_ROUTE, $urandom);
         reg_write(`OFS_LATCH, {31'h0, ~ml[i][0]});
         chk_reg(`OFS_ROUTE, exp_route(ml[i]));
         chk_reg(`OFS_LATCH, {31'h0, ml[i][0]});
         prev = ml[i];
      end
      reg_write(`OFS_MACRO, 32'h0000_0005);
      chk_reg(`OFS_MACRO, 32'h0000_0000);
      apply_macro(3'h4);
      v = {21'h0, 3'($urandom % 6), 1'b0, 3'($urandom % 6), 1'b0, DEST_PERMIT};
      reg_write(`OFS_ROUTE, v);
      reg_write(`OFS_LATCH, 32'h0000_0001);
      chk_reg(`OFS_ROUTE, v);
      chk_reg(`OFS_LATCH, 32'h0000_0001);
      apply_macro(3'h0);
      set_pins(1'b0, 1'b1, 1'b0);
      `CHK({run_en, run_rev}, 2'b10, "forward run")
      set_pins(1'b0, 1'b0, 1'b1);
      `CHK({run_en, run_rev}, 2'b11, "reverse run")
      set_pins(1'b0, 1'b0, 1'b0);
      `CHK(run_en, 1'b0, "released")
      apply_macro(3'h2);
      set_pins(1'b0, 1'b1, 1'b1);
      `CHK({run_en, run_rev}, 2'b11, "run with reverse")
      set_pins(1'b0, 1'b1, 1'b0);
      `CHK({run_en, run_rev}, 2'b10, "run forward")
      set_pins(1'b0, 1'b0, 1'b0);
      `CHK(run_en, 1'b0, "run dropped")
      apply_macro(3'h3);
      set_pins(1'b0, 1'b1, 1'b0);
      `CHK(run_en, 1'b0, "press without permit")
      set_pins(1'b0, 1'b0, 1'b0);
      `CHK(run_en, 1'b0, "no permit")
      set_pins(1'b1, 1'b1, 1'b0);
      set_pins(1'b1, 1'b0, 1'b0);
      `CHK(run_en, 1'b1, "latched run")
      set_pins(1'b0, 1'b0, 1'b0);
      `CHK(run_en, 1'b0, "permit lost")
      apply_macro(3'h0);
      for (int i = 0; i < 8; i++)
         spin_run(i % 4, 1'b0, 3'h0, 1'b0);
      spin_run(1, 1'b1, 3'h0, 1'b0);
      spin_run(1, 1'b0, 3'h2, 1'b0);
      spin_run(1, 1'b0, 3'h0, 1'b1);
      spin_run(0, 1'b0, 3'h0, 1'b1);
      // drive reset between runs: first enable in the measure-each-enable mode skips the test
      @(posedge clk);
      rst <= 1'b1;
      cyc(6);
      rst <= 1'b0;
      fresh = 1'b1;
      spin_run(1, 1'b0, 3'h1, 1'b0);
      spin_run(1, 1'b0, 3'h1, 1'b0);
      repeat (4) begin
         v = $urandom % 101;
         @(posedge clk);
         closed <= 1'($urandom);
         fbk    <= 2'($urandom);
         reg_write(`OFS_SCALE, v);
         reg_write(`OFS_SCALE, 32'(101 + $urandom % 27));
         chk_reg(`OFS_SCALE, v);
         `CHK(dscale, (closed && fbk != 2'h1 && fbk != 2'h3) ? 7'h00 : v[6:0], "scale output")
      end
      complete_run();
   end
endmodule : test_drive_start_stop_sequencer
`default_nettype wire
